//--- design/pct_timer.sv
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Base tick rate is system clock over two to the divider select.
// - Divider select unbuffered; software changes it only while stopped.
// - Base count advances on divided ticks only while run enable is set.
// - Count write replaces count at once; software stops timer first.
// - Reading count high byte latches low byte for next low read.
// - Output mode: period and compare preloads copy on overflow or stop.
// - High byte written first; no preload copy between the two writes.
// - Compare above period gives constant output set by polarity.
// - Output low below compare, high otherwise; polarity inverts.
// - Output mode count equal compare sets match flag, keeps counting.
// - Output mode count equal period sets overflow, clears and restarts.
// - Input taken from one of two pins by pin-function select.
// - Optional filter over four system clocks, five cycles of lag.
// - Edge detector finds rising and falling edges of filtered input.
// - Capture edge select 0 rising/high width, 1 falling/low width.
// - Capture: first edge restarts, opposite captures compare, next captures period.
// - Capture count 0xffff before closing edge: overflow, restart, period 0xffff.
// - Counter mode target preload copies on reached, overflow or stop.
// - Target high byte first; no copy between the two writes.
// - Counter mode edge select 1 counts rising, 0 falling edges.
// - First edge restarts count; edges tally; target reached captures period, clears.
// - Counter mode count 0xffff: overflow flag, clear count, keep tally.
// - Mode 00 capture, 01 output, 10 counter, 11 other modes.
// - Capture overflow compare 0 for low, 0xffff for high, polarity swaps.
// - Flags read 1 pending; writing 0 clears, writing 1 does nothing.
module pct_timer
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        pin_a,
   input  wire logic        pin_b,
   output logic             pwm_out,
   output logic             irq
);
   // ****************************************
   // Bus slave
   // ****************************************
   logic [7:0]  ctrl0_q, ctrl1_q, pinsel_q, lo_latch_q, rdata_q;
   logic [15:0] cnt_q, cmp_pre_q, per_pre_q, cmp_sh_q, per_sh_q, tally_q;
   logic        cmp_hold_q, per_hold_q;
   logic        wr_q;
   logic [7:0]  waddr_q;
   logic        pwm_q, irq_q;

   wire        req       = hsel & hready & htrans[1];
   wire        rd_req    = req & ~hwrite;
   wire [7:0]  raddr     = haddr[7:0];
   wire        wr_en     = wr_q;
   wire [7:0]  wd        = hwdata[7:0];
   wire        w_ctrl0   = wr_en & (waddr_q == pct_pkg::CTRL0_ADDR);
   wire        w_ctrl1   = wr_en & (waddr_q == pct_pkg::CTRL1_ADDR);
   wire        w_cnt_hi  = wr_en & (waddr_q == pct_pkg::CNT_HI_ADDR);
   wire        w_cnt_lo  = wr_en & (waddr_q == pct_pkg::CNT_LO_ADDR);
   wire        w_cmp_hi  = wr_en & (waddr_q == pct_pkg::CMP_HI_ADDR);
   wire        w_cmp_lo  = wr_en & (waddr_q == pct_pkg::CMP_LO_ADDR);
   wire        w_per_hi  = wr_en & (waddr_q == pct_pkg::PER_HI_ADDR);
   wire        w_per_lo  = wr_en & (waddr_q == pct_pkg::PER_LO_ADDR);
   wire        w_pinsel  = wr_en & (waddr_q == pct_pkg::PINSEL_ADDR);
   wire        r_cnt_hi  = rd_req & (raddr == pct_pkg::CNT_HI_ADDR);

   pct_pkg::pct_mode_t mode;
   assign mode = pct_pkg::pct_mode_t'(ctrl0_q[pct_pkg::MODE_LSB +: 2]);
   wire [2:0] div_sel  = ctrl0_q[pct_pkg::DIV_LSB +: 3];
   wire       pol      = ctrl0_q[pct_pkg::POL_BIT];
   wire       edge_sel = ctrl0_q[pct_pkg::EDGE_BIT];
   wire       run      = ctrl1_q[pct_pkg::RUN_BIT];
   wire       filt_en  = ctrl1_q[pct_pkg::FILT_BIT];
   wire       m_out    = (mode == pct_pkg::PCT_MODE_OUTPUT);
   wire       m_cap    = (mode == pct_pkg::PCT_MODE_CAPTURE);
   wire       m_cnt    = (mode == pct_pkg::PCT_MODE_COUNT);

   logic [7:0] rd_mux;
   always_comb
   begin
      unique case (raddr)
         pct_pkg::CTRL0_ADDR:    rd_mux = ctrl0_q;
         pct_pkg::CTRL1_ADDR:    rd_mux = ctrl1_q;
         pct_pkg::CNT_HI_ADDR:   rd_mux = cnt_q[15:8];
         pct_pkg::CNT_LO_ADDR:   rd_mux = lo_latch_q;
         pct_pkg::CMP_HI_ADDR:   rd_mux = m_cap ? cmp_sh_q[15:8] : cmp_pre_q[15:8];
         pct_pkg::CMP_LO_ADDR:   rd_mux = m_cap ? cmp_sh_q[7:0] : cmp_pre_q[7:0];
         pct_pkg::PER_HI_ADDR:   rd_mux = m_out ? per_pre_q[15:8] : per_sh_q[15:8];
         pct_pkg::PER_LO_ADDR:   rd_mux = m_out ? per_pre_q[7:0] : per_sh_q[7:0];
         pct_pkg::PINSEL_ADDR:   rd_mux = pinsel_q;
         pct_pkg::TALLY_HI_ADDR: rd_mux = tally_q[15:8];
         pct_pkg::TALLY_LO_ADDR: rd_mux = tally_q[7:0];
         default:                rd_mux = pct_pkg::CTRL_RST;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q    <= 1'b0;
         waddr_q <= pct_pkg::CTRL_RST;
         rdata_q <= pct_pkg::CTRL_RST;
      end
      else
      begin
         wr_q    <= req & hwrite;
         waddr_q <= raddr;
         if (rd_req)
            rdata_q <= rd_mux;
      end
   end
   assign hrdata    = {24'h000000, rdata_q};
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ****************************************
   // Prescaler
   // ****************************************
   logic [6:0] psc_q;
   logic       tick;
   wire  [6:0] psc_mask = pct_pkg::PSC_ONES >> (3'd7 - div_sel);
   assign tick = run & ((psc_q & psc_mask) == psc_mask);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         psc_q <= 7'h00;
      else if (!run)
         psc_q <= 7'h00;
      else
         psc_q <= psc_q + 7'h01;
   end

   // ****************************************
   // Input select, filter, edges
   // ****************************************
   logic [1:0] sa_q, sb_q;
   logic [pct_pkg::FILT_CYC-1:0] fsh_q;
   logic       filt_q, prev_q;
   wire        raw   = pinsel_q[0] ? sb_q[1] : sa_q[1];
   wire        f_all1 = &fsh_q;
   wire        f_all0 = ~|fsh_q;
   wire        fin   = filt_en ? filt_q : raw;
   wire        rise  = fin & ~prev_q;
   wire        fall  = ~fin & prev_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sa_q   <= 2'b00;
         sb_q   <= 2'b00;
         fsh_q  <= '0;
         filt_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         sa_q   <= {sa_q[0], pin_a};
         sb_q   <= {sb_q[0], pin_b};
         fsh_q  <= {fsh_q[pct_pkg::FILT_CYC-2:0], raw};
         if (f_all1)
            filt_q <= 1'b1;
         else if (f_all0)
            filt_q <= 1'b0;
         prev_q <= fin;
      end
   end

   // ****************************************
   // Event decode
   // ****************************************
   wire act_cap  = edge_sel ? fall : rise;
   wire opp_cap  = edge_sel ? rise : fall;
   wire act_cnt  = edge_sel ? rise : fall;
   wire at_max   = tick & (cnt_q == pct_pkg::CNT_MAX);
   wire out_ovf  = m_out & tick & (cnt_q == per_sh_q);
   wire out_mat  = m_out & tick & (cnt_q == cmp_sh_q);
   pct_pkg::pct_cap_t cap_q;
   wire cap_open = m_cap & run & act_cap & (cap_q == pct_pkg::PCT_CAP_IDLE);
   wire cap_mid  = m_cap & run & opp_cap & (cap_q == pct_pkg::PCT_CAP_FIRST);
   wire cap_end  = m_cap & run & act_cap & (cap_q != pct_pkg::PCT_CAP_IDLE);
   wire cap_ovf  = m_cap & at_max & ~cap_end;
   wire cnt_edge = m_cnt & run & act_cnt;
   wire cnt_hit  = cnt_edge & (cap_q != pct_pkg::PCT_CAP_IDLE)
                   & ((tally_q + 16'h0001) == cmp_sh_q);
   wire cnt_ovf  = m_cnt & at_max & ~cnt_hit;
   wire ovf_ev   = out_ovf | cap_ovf | cnt_ovf;
   wire hold     = cmp_hold_q | per_hold_q;
   wire load_out = m_out & (out_ovf | ~run) & ~hold;
   wire load_cnt = m_cnt & (cnt_hit | cnt_ovf | ~run) & ~cmp_hold_q;
   wire lvl_hi   = fin ^ pol;

   // ****************************************
   // Base count and capture sequence
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q   <= pct_pkg::ZERO16;
         tally_q <= pct_pkg::ZERO16;
         cap_q   <= pct_pkg::PCT_CAP_IDLE;
      end
      else
      begin
         if (w_cnt_hi)
            cnt_q[15:8] <= wd;
         else if (w_cnt_lo)
            cnt_q[7:0] <= wd;
         else if (cap_open | cap_end | cnt_hit | ovf_ev)
            cnt_q <= pct_pkg::ZERO16;
         else if (cnt_edge & (cap_q == pct_pkg::PCT_CAP_IDLE))
            cnt_q <= pct_pkg::ZERO16;
         else if (tick)
            cnt_q <= cnt_q + 16'h0001;
         if (!run | ~(m_cap | m_cnt))
            cap_q <= pct_pkg::PCT_CAP_IDLE;
         else if (cap_open | cap_end)
            cap_q <= pct_pkg::PCT_CAP_FIRST;
         else if (cap_mid)
            cap_q <= pct_pkg::PCT_CAP_MEAS;
         else if (cnt_edge)
            cap_q <= pct_pkg::PCT_CAP_MEAS;
         if (!m_cnt | cnt_hit)
            tally_q <= pct_pkg::ZERO16;
         else if (cnt_edge)
            tally_q <= tally_q + 16'h0001;
      end
   end

   // ****************************************
   // Preload, shadow, byte latch
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cmp_pre_q  <= pct_pkg::ZERO16;
         per_pre_q  <= pct_pkg::ZERO16;
         cmp_sh_q   <= pct_pkg::ZERO16;
         per_sh_q   <= pct_pkg::ZERO16;
         cmp_hold_q <= 1'b0;
         per_hold_q <= 1'b0;
         lo_latch_q <= pct_pkg::CTRL_RST;
      end
      else
      begin
         if (r_cnt_hi)
            lo_latch_q <= cnt_q[7:0];
         if (w_cmp_hi)
            cmp_pre_q[15:8] <= wd;
         if (w_cmp_lo)
            cmp_pre_q[7:0] <= wd;
         if (w_per_hi)
            per_pre_q[15:8] <= wd;
         if (w_per_lo)
            per_pre_q[7:0] <= wd;
         cmp_hold_q <= w_cmp_hi | (cmp_hold_q & ~w_cmp_lo);
         per_hold_q <= w_per_hi | (per_hold_q & ~w_per_lo);
         if (load_out)
         begin
            cmp_sh_q <= cmp_pre_q;
            per_sh_q <= per_pre_q;
         end
         else if (load_cnt)
            cmp_sh_q <= cmp_pre_q;
         else if (cap_mid)
            cmp_sh_q <= cnt_q;
         else if (cap_ovf)
            cmp_sh_q <= lvl_hi ? pct_pkg::CNT_MAX : pct_pkg::ZERO16;
         if (cap_end | cnt_hit)
            per_sh_q <= cnt_q;
         else if (cap_ovf)
            per_sh_q <= pct_pkg::CNT_MAX;
      end
   end

   // ****************************************
   // Control, flags, output
   // ****************************************
   wire set_m = out_mat | cap_mid;
   wire set_e = cap_end | cnt_hit;
   wire set_o = ovf_ev;
   wire [7:0] c1_wr = {wd[7:5] & ctrl1_q[7:5], wd[4:2], ctrl1_q[1], wd[0]};
   wire [7:0] c1_b  = w_ctrl1 ? c1_wr : ctrl1_q;
   wire [7:0] c1_d  = c1_b | {set_m, set_e, set_o, 5'h00};
   wire pwm_d = (cmp_sh_q > per_sh_q) ? pol
              : ((cnt_q < cmp_sh_q) ? pol : ~pol);
   wire irq_d = (c1_d[pct_pkg::MFLAG_BIT] & ctrl0_q[pct_pkg::MIE_BIT])
              | (c1_d[pct_pkg::EFLAG_BIT] & c1_d[pct_pkg::EIE_BIT])
              | (c1_d[pct_pkg::OFLAG_BIT] & c1_d[pct_pkg::OIE_BIT]);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl0_q  <= pct_pkg::CTRL_RST;
         ctrl1_q  <= pct_pkg::CTRL_RST;
         pinsel_q <= pct_pkg::CTRL_RST;
         pwm_q    <= 1'b0;
         irq_q    <= 1'b0;
      end
      else
      begin
         if (w_ctrl0)
            ctrl0_q <= wd;
         if (w_pinsel)
            pinsel_q <= {7'h00, wd[0]};
         ctrl1_q <= c1_d;
         pwm_q   <= m_out ? pwm_d : pol;
         irq_q   <= irq_d;
      end
   end
   assign pwm_out = pwm_q;
   assign irq     = irq_q;

   // ****************************************
   // Checks
   // ****************************************
   ovf_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
      out_ovf && !w_cnt_hi && !w_cnt_lo |=> cnt_q == 16'h0000 && ctrl1_q[5])
      else $error("output overflow did not restart count");
   match_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      out_mat |=> ctrl1_q[7])
      else $error("match flag not set");
   halt_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !run && !w_cnt_hi && !w_cnt_lo && !cap_open && !cnt_edge |=> $stable(cnt_q))
      else $error("count moved while stopped");
   cap_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_end |=> per_sh_q == $past(cnt_q) && ctrl1_q[6])
      else $error("capture period wrong");
   cap_ovf_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_ovf |=> per_sh_q == 16'hffff && ctrl1_q[5])
      else $error("capture overflow wrong");
   tally_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cnt_ovf && !cnt_edge |=> $stable(tally_q))
      else $error("tally lost on overflow");
   hold_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cmp_hold_q && m_out |=> $stable(cmp_sh_q))
      else $error("shadow loaded between byte writes");
   flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      w_ctrl1 && wd[7] && !ctrl1_q[7] && !set_m |=> !ctrl1_q[7])
      else $error("writing one set the flag");
   latch_lo_a: assert property (@(posedge hclk) disable iff (!hresetn)
      r_cnt_hi |=> lo_latch_q == $past(cnt_q[7:0]))
      else $error("low byte not latched");
endmodule

`default_nettype wire

//--- design/pct_pkg.sv
package pct_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] CTRL0_ADDR    = 8'h00;
   localparam logic [7:0] CTRL1_ADDR    = 8'h04;
   localparam logic [7:0] CNT_HI_ADDR   = 8'h08;
   localparam logic [7:0] CNT_LO_ADDR   = 8'h0c;
   localparam logic [7:0] CMP_HI_ADDR   = 8'h10;
   localparam logic [7:0] CMP_LO_ADDR   = 8'h14;
   localparam logic [7:0] PER_HI_ADDR   = 8'h18;
   localparam logic [7:0] PER_LO_ADDR   = 8'h1c;
   localparam logic [7:0] PINSEL_ADDR   = 8'h20;
   localparam logic [7:0] TALLY_HI_ADDR = 8'h24;
   localparam logic [7:0] TALLY_LO_ADDR = 8'h28;

   // ****************************************
   // Control zero fields
   // ****************************************
   localparam int DIV_LSB    = 5;
   localparam int POL_BIT    = 4;
   localparam int MIE_BIT    = 3;
   localparam int EDGE_BIT   = 2;
   localparam int MODE_LSB   = 0;
   // Control one fields
   localparam int MFLAG_BIT  = 7;
   localparam int EFLAG_BIT  = 6;
   localparam int OFLAG_BIT  = 5;
   localparam int EIE_BIT    = 4;
   localparam int OIE_BIT    = 3;
   localparam int FILT_BIT   = 2;
   localparam int RUN_BIT    = 0;

   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [15:0] ZERO16     = 16'h0000;
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [6:0]  PSC_ONES   = 7'h7f;
   localparam logic [1:0]  FILT_LAST  = 2'h3;

   // Filter settling period
   localparam int FILT_NS  = 16;
   localparam int CLK_PS   = 4000;
   localparam int FILT_CYC = (FILT_NS * 1000) / CLK_PS;

   typedef enum logic [1:0]
   {
      PCT_MODE_CAPTURE = 2'b00,
      PCT_MODE_OUTPUT  = 2'b01,
      PCT_MODE_COUNT   = 2'b10,
      PCT_MODE_OTHER   = 2'b11
   } pct_mode_t;

   typedef enum logic [1:0]
   {
      PCT_CAP_IDLE  = 2'b00,
      PCT_CAP_FIRST = 2'b01,
      PCT_CAP_MEAS  = 2'b10
   } pct_cap_t;
endpackage

//--- dv/pct_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Pulse source on one timer input pin
// ****************************************
module pct_pulse_src
(
   input  wire logic        hclk,
   input  wire logic        en,
   input  wire logic [15:0] hi_cyc,
   input  wire logic [15:0] lo_cyc,
   input  wire logic        idle_lvl,
   output logic             pin
);
   logic [15:0] cnt_q;

   initial pin = 1'h0;
   initial cnt_q = 16'h0000;

   // Holds a steady level while off, so no stray edges reach the timer
   always @(posedge hclk)
   begin
      if (!en)
      begin
         pin <= idle_lvl;
         cnt_q <= 16'h0000;
      end
      else if (cnt_q >= hi_cyc + lo_cyc - 16'h0001)
      begin
         cnt_q <= 16'h0000;
         pin <= 1'h1;
      end
      else
      begin
         cnt_q <= cnt_q + 16'h0001;
         pin <= (cnt_q + 16'h0001 < hi_cyc);
      end
   end
endmodule

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        pin_a;
   logic        pin_b;
   logic        pwm_out;
   logic        irq;
   logic        src_en;
   logic        idle_a;
   int          n_mismatch;
   int          n_checks;

   pct_pulse_src src_a (.hclk(hclk), .en(src_en), .hi_cyc(16'h001e), .lo_cyc(16'h0046), .idle_lvl(idle_a), .pin(pin_a));
   pct_pulse_src src_b (.hclk(hclk), .en(src_en), .hi_cyc(16'h0028), .lo_cyc(16'h003c), .idle_lvl(1'h0), .pin(pin_b));

   pct_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pin_a(pin_a), .pin_b(pin_b), .pwm_out(pwm_out), .irq(irq));

   always #2 hclk = ~hclk;

   // ****************************************
   // Bus and check helpers
   // ****************************************
   task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
      hsel <= 1'h1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata[7:0];
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'h1, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      bus(a, 1'h0, 8'h00, q);
   endtask

   // High byte first so no shadow load splits the pair
   task automatic wr16(input logic [7:0] ah, input logic [15:0] v);
      wr(ah, v[15:8]);
      wr(ah + 8'h04, v[7:0]);
   endtask

   task automatic rd16(input logic [7:0] ah, output logic [15:0] v);
      rd(ah, v[15:8]);
      rd(ah + 8'h04, v[7:0]);
   endtask

   task automatic chk(input logic [15:0] got, input int lo, input int hi);
      n_checks++;
      if (^got === 1'bx || got < lo || got > hi)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got %h want %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic ctl0(input logic [2:0] dv, input logic pol, input logic edg, input logic [1:0] md);
      wr(pct_pkg::CTRL0_ADDR, {dv, pol, 1'h1, edg, md});
   endtask

   // Writes zero to all flags, so it also clears them
   task automatic ctl1(input logic run, input logic filt);
      wr(pct_pkg::CTRL1_ADDR, {5'h03, filt, 1'h0, run});
   endtask

   task automatic poll(input int b, input int lim);
      logic [7:0] q;
      int         i;
      i = 0;
      rd(pct_pkg::CTRL1_ADDR, q);
      while (q[b] !== 1'h1 && i < lim)
      begin
         rd(pct_pkg::CTRL1_ADDR, q);
         i++;
      end
      chk(q[b], 1, 1);
   endtask

   task automatic hcount(input int n, output int c);
      c = 0;
      repeat (n)
      begin
         @(posedge hclk);
         if (pwm_out === 1'h1) c++;
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] q;
      rd(pct_pkg::CTRL0_ADDR, q);
      chk(q, 0, 0);
      rd(pct_pkg::CTRL1_ADDR, q);
      chk(q, 0, 0);
      rd(8'hfc, q);
      chk(q, 0, 0);
      chk(irq, 0, 0);
      chk(hresp, 0, 0);
      $display("done reset");
   endtask

   task automatic t_output;
      logic [7:0] q;
      int         c;
      wr16(pct_pkg::PER_HI_ADDR, 16'h0009);
      wr16(pct_pkg::CMP_HI_ADDR, 16'h0004);
      ctl0(3'h0, 1'h0, 1'h0, 2'h1);
      ctl1(1'h1, 1'h0);
      repeat (30) @(posedge hclk);
      hcount(20, c);
      chk(c, 12, 12);
      wr16(pct_pkg::CMP_HI_ADDR, 16'h0007);
      repeat (15) @(posedge hclk);
      hcount(20, c);
      chk(c, 6, 6);
      rd(pct_pkg::CTRL1_ADDR, q);
      chk(q, 'hb9, 'hb9);
      chk(irq, 1, 1);
      ctl1(1'h0, 1'h0);
      // A flag may be set at the very edge that stops the timer; set wins
      ctl1(1'h0, 1'h0);
      repeat (2) @(posedge hclk);
      chk(irq, 0, 0);
      wr(pct_pkg::CTRL1_ADDR, 8'hf8);
      rd(pct_pkg::CTRL1_ADDR, q);
      chk(q, 'h18, 'h18);
      ctl0(3'h0, 1'h1, 1'h0, 2'h1);
      ctl1(1'h1, 1'h0);
      repeat (10) @(posedge hclk);
      hcount(20, c);
      chk(c, 14, 14);
      ctl1(1'h0, 1'h0);
      wr16(pct_pkg::CMP_HI_ADDR, 16'h0014);
      for (int p = 0; p < 2; p++)
      begin
         ctl0(3'h0, p[0], 1'h0, 2'h1);
         ctl1(1'h1, 1'h0);
         repeat (10) @(posedge hclk);
         hcount(20, c);
         chk(c, 20 * p, 20 * p);
         ctl1(1'h0, 1'h0);
      end
      $display("done output");
   endtask

   task automatic t_count;
      logic [15:0] v;
      logic [15:0] w;
      logic [7:0]  q;
      for (int d = 3; d < 8; d += 4)
      begin
         wr16(pct_pkg::CNT_HI_ADDR, 16'h0000);
         ctl0(d[2:0], 1'h0, 1'h0, 2'h0);
         ctl1(1'h1, 1'h0);
         repeat (10 << d) @(posedge hclk);
         ctl1(1'h0, 1'h0);
         rd16(pct_pkg::CNT_HI_ADDR, v);
         chk(v, 9, 11);
         repeat (20) @(posedge hclk);
         rd16(pct_pkg::CNT_HI_ADDR, w);
         chk(w, v, v);
      end
      wr16(pct_pkg::CNT_HI_ADDR, 16'h00f0);
      ctl0(3'h0, 1'h0, 1'h0, 2'h0);
      ctl1(1'h1, 1'h0);
      rd(pct_pkg::CNT_HI_ADDR, q);
      chk(q, 0, 0);
      repeat (40) @(posedge hclk);
      rd(pct_pkg::CNT_LO_ADDR, q);
      chk(q, 'hf0, 'hff);
      ctl1(1'h0, 1'h0);
      $display("done count");
   endtask

   task automatic t_capture;
      logic [15:0] v;
      logic [7:0]  q;
      logic        e;
      logic        s;
      int          w;
      src_en <= 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         e = i[0];
         s = i[0] ^ i[1];
         w = s ? (e ? 60 : 40) : (e ? 70 : 30);
         wr(pct_pkg::PINSEL_ADDR, {7'h00, s});
         ctl0(3'h0, 1'h0, e, 2'h0);
         // Filter switched while stopped, so the mux change makes no false edge
         ctl1(1'h0, i[1]);
         ctl1(1'h1, i[1]);
         poll(pct_pkg::EFLAG_BIT, 200);
         rd16(pct_pkg::CMP_HI_ADDR, v);
         chk(v, w - 2, w + 2);
         rd16(pct_pkg::PER_HI_ADDR, v);
         chk(v, 98, 102);
         rd(pct_pkg::CTRL1_ADDR, q);
         chk(q[7], 1, 1);
         ctl1(1'h0, 1'h0);
      end
      $display("done capture");
   endtask

   task automatic t_counter;
      logic [15:0] v;
      wr(pct_pkg::PINSEL_ADDR, 8'h01);
      wr16(pct_pkg::CMP_HI_ADDR, 16'h0003);
      ctl0(3'h0, 1'h0, 1'h1, 2'h2);
      ctl1(1'h1, 1'h0);
      poll(pct_pkg::EFLAG_BIT, 400);
      rd16(pct_pkg::PER_HI_ADDR, v);
      chk(v, 198, 202);
      ctl1(1'h0, 1'h0);
      $display("done counter");
   endtask

   // Pin held at a steady level with no edges, so only the full count can end the wait
   task automatic t_overflow;
      logic [15:0] v;
      src_en <= 1'h0;
      wr(pct_pkg::PINSEL_ADDR, 8'h00);
      for (int lv = 0; lv < 2; lv++)
      begin
         idle_a <= lv[0];
         wr16(pct_pkg::CNT_HI_ADDR, 16'hff00);
         ctl0(3'h0, 1'h0, 1'h0, 2'h0);
         ctl1(1'h1, 1'h0);
         poll(pct_pkg::OFLAG_BIT, 400);
         rd16(pct_pkg::PER_HI_ADDR, v);
         chk(v, 'hffff, 'hffff);
         rd16(pct_pkg::CMP_HI_ADDR, v);
         chk(v, 'hffff * lv, 'hffff * lv);
         ctl1(1'h0, 1'h0);
      end
      $display("done overflow");
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #80000;
      n_mismatch++;
      summarize();
   end

   initial
   begin
      hclk = 1'h0;
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      src_en = 1'h0;
      idle_a = 1'h0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      t_reset();
      t_output();
      t_count();
      t_capture();
      t_counter();
      t_overflow();
      summarize();
   end
endmodule

`default_nettype wire
